// ### logic/btam_monitor.v
// Top of the branch trip and alarm monitor for four branches.
// Assumes digitised voltage, currents, run time and temperature arrive
// synchronous to clk_i, and software uses the plain register port.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "btam_regs.vh"
module btam_monitor
#(
  parameter         REDUNDANT   = 0,
  parameter [25:0]  OVTRIP_CYC  = `BTAM_T_OVTRIP_MS * `BTAM_CLK_KHZ,
  parameter [25:0]  SC_CYC      = `BTAM_T_SC_MS * `BTAM_CLK_KHZ,
  parameter [25:0]  RED_CYC     = `BTAM_T_RED_MS * `BTAM_CLK_KHZ,
  parameter [25:0]  STD_CYC     = `BTAM_T_STD_MS * `BTAM_CLK_KHZ,
  parameter [25:0]  FAST_CYC    = `BTAM_T_FAST_MS * `BTAM_CLK_KHZ,
  parameter [25:0]  TMP_CYC     = `BTAM_T_TMP_MS * `BTAM_CLK_KHZ,
  parameter [25:0]  ALT_CYC     = `BTAM_T_ALT_MS * `BTAM_CLK_KHZ
)
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [9:0]  volt_i,
  input  wire [7:0]  cur0_i,
  input  wire [7:0]  cur1_i,
  input  wire [7:0]  cur2_i,
  input  wire [7:0]  cur3_i,
  input  wire [9:0]  runtime_i,
  input  wire [7:0]  temp_i,
  input  wire        external_trip_in_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wr_data_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rd_data_o,
  output reg  [3:0]  branch_on_o,
  output reg         trip_alarm_out_o,
  output reg         general_alarm_out_o,
  output reg         overheat_out_o,
  output wire [11:0] err_code_o,
  output wire [9:0]  err_value_o,
  output wire        err_show_value_o,
  output reg         irq_o
);

  // ==========================================================
  // Helpers
  function [7:0] clamp_trip;
    input [7:0] lvl;
    begin
      if (REDUNDANT != 0 && lvl > `BTAM_RED_MAX_LVL)
        clamp_trip = `BTAM_RED_MAX_LVL;
      else
        clamp_trip = lvl;
    end
  endfunction

  function [1:0] first_set;
    input [3:0] v;
    begin
      if (v[0])
        first_set = 2'd0;
      else if (v[1])
        first_set = 2'd1;
      else if (v[2])
        first_set = 2'd2;
      else
        first_set = 2'd3;
    end
  endfunction

  // ==========================================================
  // Registers
  reg  [9:0]  ov_lvl_r;
  reg  [9:0]  uv_lvl_r;
  reg  [9:0]  rt_lvl_r;
  reg  [7:0]  tmp_lvl_r;
  reg  [18:0] br_cfg_r [0:3];
  reg  [7:0]  status_r;
  reg  [7:0]  mask_r;
  reg  [3:0]  cut_sc_r;
  reg  [3:0]  cut_lvl_r;
  reg  [3:0]  cut_ext_r;
  reg         cut_all_r;
  reg  [7:0]  ev_prev_r;
  reg  [11:0] code_nxt;
  reg  [9:0]  value_nxt;
  reg         alt_nxt;
  reg  [31:0] rd_nxt;
  reg  [7:0]  status_nxt;

  wire        fault_rst_w = wr_i && addr_i == `BTAM_ADDR_CTRL && wr_data_i[`BTAM_CTRL_FRST];
  wire [31:0] cur_w       = {cur3_i, cur2_i, cur1_i, cur0_i};
  wire [3:0]  sc_hit_w;
  wire [3:0]  red_hit_w;
  wire [3:0]  lvl_hit_w;
  wire [3:0]  alm_hit_w;
  wire [3:0]  ext_en_w;
  wire        ovtrip_hit_w;
  wire        tmp_hit_w;

  // ==========================================================
  // Fixed voltage trip and temperature persistence
  btam_persist u_ovtrip
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .cond_i  (volt_i > `BTAM_OV_TRIP_LVL),
    .limit_i (OVTRIP_CYC),
    .hit_o   (ovtrip_hit_w)
  );

  btam_persist u_tmp
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .cond_i  ({1'b0, temp_i} >= {1'b0, tmp_lvl_r} + 9'h001),
    .limit_i (TMP_CYC),
    .hit_o   (tmp_hit_w)
  );

  // ==========================================================
  // Per-branch current checks
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_br
      wire [7:0] cur = cur_w[8*b+7:8*b];
      wire [7:0] tl  = clamp_trip(br_cfg_r[b][`BTAM_BR_TRIP_LSB+7:`BTAM_BR_TRIP_LSB]);
      wire [7:0] al  = br_cfg_r[b][`BTAM_BR_ALM_LSB+7:`BTAM_BR_ALM_LSB];
      assign ext_en_w[b] = br_cfg_r[b][`BTAM_BR_EXT_EN];

      btam_persist u_sc
      (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .cond_i  (cur >= `BTAM_SC_LVL),
        .limit_i (SC_CYC),
        .hit_o   (sc_hit_w[b])
      );

      // Redundant path is active only on the redundant variant; elsewhere its condition is held low
      btam_persist u_red
      (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .cond_i  (REDUNDANT != 0 && cur > `BTAM_RED_LVL),
        .limit_i (RED_CYC),
        .hit_o   (red_hit_w[b])
      );

      btam_persist u_lvl
      (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .cond_i  (cur > tl),
        .limit_i (br_cfg_r[b][`BTAM_BR_TRIP_FAST] ? FAST_CYC : STD_CYC),
        .hit_o   (lvl_hit_w[b])
      );

      btam_persist u_alm
      (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .cond_i  (cur > al),
        .limit_i (br_cfg_r[b][`BTAM_BR_ALM_FAST] ? FAST_CYC : STD_CYC),
        .hit_o   (alm_hit_w[b])
      );
    end
  endgenerate

  // ==========================================================
  // Alarm conditions (no cut-off) and the branch trip flag
  wire ov_alm_w  = volt_i > ov_lvl_r;
  wire uv_alm_w  = volt_i < uv_lvl_r;
  wire rt_alm_w  = rt_lvl_r != 10'h000 && runtime_i >= rt_lvl_r;
  wire oc_alm_w  = |alm_hit_w;
  wire br_trip_w = |(cut_sc_r | cut_lvl_r);

  // ==========================================================
  // Latched cut-offs, held until a fault reset
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cut_all_r <= 1'b0;
      cut_sc_r  <= 4'h0;
      cut_lvl_r <= 4'h0;
      cut_ext_r <= 4'h0;
    end
    else
    begin
      // A live fault re-arms over a reset in the same cycle
      cut_all_r <= ovtrip_hit_w | (cut_all_r & ~fault_rst_w);
      cut_sc_r  <= sc_hit_w | (cut_sc_r & {4{~fault_rst_w}});
      cut_lvl_r <= lvl_hit_w | red_hit_w | (cut_lvl_r & {4{~fault_rst_w}});
      cut_ext_r <= ({4{external_trip_in_i}} & ext_en_w)
                   | (cut_ext_r & {4{~fault_rst_w}});
    end
  end

  // ==========================================================
  // Output pins: high is healthy, low signals the condition
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      branch_on_o         <= 4'h0;
      trip_alarm_out_o    <= 1'b1;
      general_alarm_out_o <= 1'b1;
      overheat_out_o      <= 1'b1;
    end
    else
    begin
      branch_on_o         <= ~(cut_sc_r | cut_lvl_r | cut_ext_r | {4{cut_all_r}});
      trip_alarm_out_o    <= ~(cut_all_r | br_trip_w);
      general_alarm_out_o <= ~(ov_alm_w | uv_alm_w | oc_alm_w | rt_alm_w);
      overheat_out_o      <= ~tmp_hit_w;
    end
  end

  // ==========================================================
  // Error code selection, most severe first
  always @*
  begin
    code_nxt  = `BTAM_CODE_NONE;
    value_nxt = 10'h000;
    alt_nxt   = 1'b0;
    if (cut_all_r)
    begin
      code_nxt  = `BTAM_CODE_OVTRIP;
      value_nxt = volt_i;
    end
    else if (|cut_sc_r)
      code_nxt = `BTAM_CODE_BRTRIP;
    else if (|cut_lvl_r)
    begin
      code_nxt  = `BTAM_CODE_BRTRIP;
      value_nxt = {2'b00, cur_w[8*first_set(cut_lvl_r) +: 8]};
      alt_nxt   = 1'b1;
    end
    else if (|cut_ext_r)
      code_nxt = `BTAM_CODE_EXT;
    else if (tmp_hit_w)
    begin
      code_nxt  = `BTAM_CODE_TMP;
      value_nxt = {2'b00, temp_i};
      alt_nxt   = 1'b1;
    end
    else if (ov_alm_w)
    begin
      code_nxt  = `BTAM_CODE_OVALM;
      value_nxt = volt_i;
      alt_nxt   = 1'b1;
    end
    else if (uv_alm_w)
    begin
      code_nxt  = `BTAM_CODE_UVALM;
      value_nxt = volt_i;
      alt_nxt   = 1'b1;
    end
    else if (oc_alm_w)
    begin
      code_nxt  = `BTAM_CODE_OCALM;
      value_nxt = {2'b00, cur_w[8*first_set(alm_hit_w) +: 8]};
      alt_nxt   = 1'b1;
    end
    else if (rt_alm_w)
    begin
      code_nxt  = `BTAM_CODE_RTALM;
      value_nxt = runtime_i;
      alt_nxt   = 1'b1;
    end
  end

  btam_disp u_disp
  (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .code_i       (code_nxt),
    .value_i      (value_nxt),
    .alt_i        (alt_nxt),
    .period_i     (ALT_CYC),
    .code_o       (err_code_o),
    .value_o      (err_value_o),
    .show_value_o (err_show_value_o)
  );

  // ==========================================================
  // Interrupt events: rising edges of each condition
  wire [7:0] ev_w = {tmp_hit_w, rt_alm_w, oc_alm_w, uv_alm_w, ov_alm_w,
                     |cut_ext_r, br_trip_w, cut_all_r};
  wire [7:0] ev_rise_w = ev_w & ~ev_prev_r;

  always @*
  begin
    status_nxt = status_r;
    if (wr_i && addr_i == `BTAM_ADDR_STATUS)
      status_nxt = status_nxt & ~wr_data_i[7:0];
    // Set wins over a clear in the same cycle
    status_nxt = status_nxt | ev_rise_w;
  end

  // ==========================================================
  // Register writes
  integer i;
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ov_lvl_r  <= `BTAM_RST_OV_LVL;
      uv_lvl_r  <= `BTAM_RST_UV_LVL;
      rt_lvl_r  <= `BTAM_RST_RT_LVL;
      tmp_lvl_r <= `BTAM_RST_TMP_LVL;
      for (i = 0; i < 4; i = i + 1)
        br_cfg_r[i] <= `BTAM_RST_BR_CFG;
      status_r  <= 8'h00;
      mask_r    <= 8'h00;
      ev_prev_r <= 8'h00;
      irq_o     <= 1'b0;
    end
    else
    begin
      status_r  <= status_nxt;
      ev_prev_r <= ev_w;
      irq_o     <= |(status_nxt & mask_r);
      if (wr_i)
      begin
        case (addr_i)
          `BTAM_ADDR_OV_LVL:  ov_lvl_r  <= wr_data_i[9:0];
          `BTAM_ADDR_UV_LVL:  uv_lvl_r  <= wr_data_i[9:0];
          `BTAM_ADDR_RT_LVL:  rt_lvl_r  <= wr_data_i[9:0];
          `BTAM_ADDR_TMP_LVL: tmp_lvl_r <= wr_data_i[7:0];
          `BTAM_ADDR_MASK:    mask_r    <= wr_data_i[7:0];
          default:
          begin
            for (i = 0; i < 4; i = i + 1)
              if (addr_i == `BTAM_ADDR_BR_CFG0 + 8'h04 * i[7:0])
                br_cfg_r[i] <= wr_data_i[18:0];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register reads, data valid the cycle after the strobe
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (addr_i)
      `BTAM_ADDR_OV_LVL:  rd_nxt = {22'h000000, ov_lvl_r};
      `BTAM_ADDR_UV_LVL:  rd_nxt = {22'h000000, uv_lvl_r};
      `BTAM_ADDR_RT_LVL:  rd_nxt = {22'h000000, rt_lvl_r};
      `BTAM_ADDR_TMP_LVL: rd_nxt = {24'h000000, tmp_lvl_r};
      `BTAM_ADDR_STATUS:  rd_nxt = {24'h000000, status_r};
      `BTAM_ADDR_MASK:    rd_nxt = {24'h000000, mask_r};
      `BTAM_ADDR_STATE:   rd_nxt = {4'h0, err_code_o, cut_all_r, cut_ext_r, cut_lvl_r, cut_sc_r,
                                    overheat_out_o, general_alarm_out_o, trip_alarm_out_o};
      `BTAM_ADDR_BR_CFG0:         rd_nxt = {13'h0000, br_cfg_r[0]};
      `BTAM_ADDR_BR_CFG0 + 8'h04: rd_nxt = {13'h0000, br_cfg_r[1]};
      `BTAM_ADDR_BR_CFG0 + 8'h08: rd_nxt = {13'h0000, br_cfg_r[2]};
      `BTAM_ADDR_BR_CFG0 + 8'h0c: rd_nxt = {13'h0000, br_cfg_r[3]};
      default:            rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (reset_i || !rd_i)
      rd_data_o <= 32'h00000000;
    else
      rd_data_o <= rd_nxt;
  end

endmodule // btam_monitor

// ### logic/btam_regs.vh
// Constants for the branch trip and alarm monitor: register offsets,
// field positions, reset values, fixed limits and timing figures.
// Assumes a 40 MHz clock and a byte-addressed plain register port.
//
// Notes on behaviour
// - Supply above 28.8 V for more than 10 ms cuts off all branches, turns the trip output off and shows A10.
// - A branch at or above 9.0 A for more than 10 ms is cut off alone, trip output off, code A11.
// - On the redundant variant a branch above 4.0 A is cut off within 0.5 s, trip output off, A11 with current.
// - Each branch has a trip level of 0.5 to 4.0 A (3.8 A on the redundant variant) that cuts off that branch; only the 3.8 A cap is clamped.
// - Each branch trip level is detected within 100 ms (standard) or 20 ms (fast) as selected.
// - Each branch alarm level turns the alarm output off and shows A22 without a cut-off, with its own speed.
// - Supply above the overvoltage alarm level turns the alarm output off and shows A20 alternating.
// - Supply below the undervoltage alarm level shows A21 alternating with the voltage, no cut-off.
// - The undervoltage alarm also turns the alarm output off.
// - Run time reaching a non-zero limit turns the alarm output off and shows A23; zero disables it.
// - Temperature at limit plus 1 degree for 1 s turns the overheat output off and shows A30.
// - The external trip input cuts off only branches whose external-trip enable is set and shows its code.
// - Trip, alarm and overheat outputs are high when healthy and go low to signal their condition.
`ifndef BTAM_REGS_VH
`define BTAM_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define BTAM_ADDR_CTRL     8'h00
`define BTAM_ADDR_OV_LVL   8'h04
`define BTAM_ADDR_UV_LVL   8'h08
`define BTAM_ADDR_RT_LVL   8'h0c
`define BTAM_ADDR_TMP_LVL  8'h10
`define BTAM_ADDR_BR_CFG0  8'h18
`define BTAM_ADDR_STATUS   8'h30
`define BTAM_ADDR_MASK     8'h34
`define BTAM_ADDR_STATE    8'h38

// ==========================================================
// Fields
`define BTAM_CTRL_FRST      0
`define BTAM_BR_TRIP_LSB    0
`define BTAM_BR_ALM_LSB     8
`define BTAM_BR_TRIP_FAST   16
`define BTAM_BR_ALM_FAST    17
`define BTAM_BR_EXT_EN      18

// ==========================================================
// Reset values (0.1 V, 0.1 A, 0.1 kh, degree units)
`define BTAM_RST_OV_LVL    10'h120
`define BTAM_RST_UV_LVL    10'h0b4
`define BTAM_RST_RT_LVL    10'h000
`define BTAM_RST_TMP_LVL   8'h50
`define BTAM_RST_BR_CFG    19'h02828

// ==========================================================
// Fixed limits
`define BTAM_OV_TRIP_LVL   10'h120
`define BTAM_SC_LVL        8'h5a
`define BTAM_RED_LVL       8'h28
`define BTAM_RED_MAX_LVL   8'h26

// ==========================================================
// Times in ms and the clock rate in kHz
`define BTAM_CLK_KHZ       40000
`define BTAM_T_OVTRIP_MS   10
`define BTAM_T_SC_MS       10
`define BTAM_T_RED_MS      500
`define BTAM_T_STD_MS      100
`define BTAM_T_FAST_MS     20
`define BTAM_T_TMP_MS      1000
`define BTAM_T_ALT_MS      500

// ==========================================================
// Display codes
`define BTAM_CODE_NONE     12'h000
`define BTAM_CODE_OVTRIP   12'ha10
`define BTAM_CODE_BRTRIP   12'ha11
`define BTAM_CODE_OVALM    12'ha20
`define BTAM_CODE_UVALM    12'ha21
`define BTAM_CODE_OCALM    12'ha22
`define BTAM_CODE_RTALM    12'ha23
`define BTAM_CODE_TMP      12'ha30
`define BTAM_CODE_EXT      12'hf0e

`endif

// ### logic/btam_persist.v
// Persistence timer: raises its hit flag once the condition has held
// for the given number of cycles without a break.
// Assumes condition and limit are synchronous to clk_i; limit >= 1.
`timescale 1ns/100ps
module btam_persist
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        cond_i,
  input  wire [25:0] limit_i,
  output reg         hit_o
);

  reg [25:0] cnt_r;

  always @(posedge clk_i)
  begin
    if (reset_i || !cond_i)
    begin
      cnt_r <= 26'h0000000;
      hit_o <= 1'b0;
    end
    else if (!hit_o)
    begin
      if (cnt_r == limit_i - 26'h0000001)
        hit_o <= 1'b1;
      else
        cnt_r <= cnt_r + 26'h0000001;
    end
  end

endmodule // btam_persist

// ### logic/btam_disp.v
// Display driver: holds the error code and alternates between showing
// the code and the measured value when alternation is asked for.
// Assumes code and value are stable for many cycles at a time.
`timescale 1ns/100ps
`include "btam_regs.vh"
module btam_disp
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [11:0] code_i,
  input  wire [9:0]  value_i,
  input  wire        alt_i,
  input  wire [25:0] period_i,
  output reg  [11:0] code_o,
  output reg  [9:0]  value_o,
  output reg         show_value_o
);

  reg [25:0] tick_r;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tick_r       <= 26'h0000000;
      code_o       <= `BTAM_CODE_NONE;
      value_o      <= 10'h000;
      show_value_o <= 1'b0;
    end
    else
    begin
      code_o  <= code_i;
      value_o <= value_i;
      // New code always shows the code first
      if (!alt_i || code_i != code_o)
      begin
        tick_r       <= 26'h0000000;
        show_value_o <= 1'b0;
      end
      else if (tick_r == period_i - 26'h0000001)
      begin
        tick_r       <= 26'h0000000;
        show_value_o <= ~show_value_o;
      end
      else
        tick_r <= tick_r + 26'h0000001;
    end
  end

endmodule // btam_disp

// ### tb/btam_plant.sv
// Far-side model: branch loads and the external trip contact.
// Assumes the bench sets the load targets; supply and heat come straight from it.
`timescale 1ns/100ps
module btam_plant
(
  input  wire [3:0]  branch_on_i,
  input  wire [31:0] load_i,
  input  wire        contact_i,
  output wire [7:0]  cur0_o,
  output wire [7:0]  cur1_o,
  output wire [7:0]  cur2_o,
  output wire [7:0]  cur3_o,
  output wire        ext_trip_o
);
  // An open branch switch carries no current, so a cut clears its own cause
  assign cur0_o = branch_on_i[0] ? load_i[7:0] : 8'h00;
  assign cur1_o = branch_on_i[1] ? load_i[15:8] : 8'h00;
  assign cur2_o = branch_on_i[2] ? load_i[23:16] : 8'h00;
  assign cur3_o = branch_on_i[3] ? load_i[31:24] : 8'h00;
  assign ext_trip_o = contact_i;
endmodule // btam_plant

// ### tb/btam_chk.sv
// Checker on the monitor's top ports.
// Assumes offsets and reset values of btam_regs.vh; shadows a few registers.
`timescale 1ns/100ps
`include "btam_regs.vh"
module btam_chk
#(
  parameter [25:0] OVTRIP_CYC = 26'd10,
  parameter [25:0] SC_CYC     = 26'd10,
  parameter [25:0] TMP_CYC    = 26'd30
)
(
  input wire        clk_i,
  input wire        reset_i,
  input wire [9:0]  volt_i,
  input wire [7:0]  cur0_i,
  input wire [7:0]  temp_i,
  input wire        external_trip_in_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wr_data_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rd_data_o,
  input wire [3:0]  branch_on_o,
  input wire        trip_alarm_out_o,
  input wire        general_alarm_out_o,
  input wire        overheat_out_o
);
  reg  [25:0] ov_n;
  reg  [25:0] sc_n;
  reg  [25:0] tp_n;
  reg  [9:0]  ov_lvl_r;
  reg  [7:0]  tp_lvl_r;
  reg  [3:0]  ext_en_r;
  reg  [2:0]  rec_r;
  wire        fw  = wr_i && addr_i == 8'h00 && wr_data_i[0];
  wire        hot = temp_i > tp_lvl_r;
  // ==========================================================
  // Helper logic: run lengths saturate so they never wrap
  always @(posedge clk_i)
  begin
    rec_r <= {rec_r[1:0], fw | reset_i};
    if (reset_i)
    begin
      ov_n <= 26'h0;
      sc_n <= 26'h0;
      tp_n <= 26'h0;
      ov_lvl_r <= `BTAM_RST_OV_LVL;
      tp_lvl_r <= `BTAM_RST_TMP_LVL;
      ext_en_r <= 4'h0;
    end
    else
    begin
      ov_n <= (volt_i > `BTAM_OV_TRIP_LVL) ? ov_n + {25'h0, ov_n != OVTRIP_CYC} : 26'h0;
      sc_n <= (cur0_i >= `BTAM_SC_LVL) ? sc_n + {25'h0, sc_n != SC_CYC} : 26'h0;
      tp_n <= hot ? tp_n + {25'h0, tp_n != TMP_CYC} : 26'h0;
      if (wr_i && addr_i == 8'h04)
        ov_lvl_r <= wr_data_i[9:0];
      if (wr_i && addr_i == 8'h10)
        tp_lvl_r <= wr_data_i[7:0];
      if (wr_i && addr_i >= 8'h18 && addr_i <= 8'h24)
        ext_en_r[addr_i[3:2] - 2'd2] <= wr_data_i[18];
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  ovtrip_cut_a : assert property (
    ov_n == OVTRIP_CYC |-> ##[0:3] (branch_on_o == 4'h0 && !trip_alarm_out_o)) else $error("late overvoltage cut");
  sc_cut_a : assert property (
    sc_n == SC_CYC |-> ##[0:3] (!branch_on_o[0] && !trip_alarm_out_o)) else $error("late short cut");
  trip_hold_a : assert property (
    !trip_alarm_out_o && !fw && rec_r == 3'h0 |=> !trip_alarm_out_o) else $error("trip released");
  branch_hold_a : assert property (
    (branch_on_o & ~$past(branch_on_o)) != 4'h0 |-> rec_r != 3'h0) else $error("branch reconnected");
  rd_idle_a : assert property (
    !$past(rd_i) |-> rd_data_o == 32'h0) else $error("read data outside slot");
  ov_alarm_a : assert property (
    volt_i > ov_lvl_r |=> !general_alarm_out_o) else $error("missed voltage alarm");
  ext_cut_a : assert property (
    external_trip_in_i |-> ##2 ((branch_on_o & ext_en_r) == 4'h0)) else $error("missed external cut");
  heat_set_a : assert property (
    tp_n == TMP_CYC |-> ##[0:3] !overheat_out_o) else $error("late overheat");
  heat_clear_a : assert property (
    $fell(hot) |-> ##[1:3] overheat_out_o) else $error("overheat stuck");
  cover property (ov_n == OVTRIP_CYC);
  cover property (external_trip_in_i && ext_en_r != 4'h0);
  cover property ($fell(general_alarm_out_o));
endmodule // btam_chk

bind btam_monitor btam_chk #(.OVTRIP_CYC(OVTRIP_CYC), .SC_CYC(SC_CYC), .TMP_CYC(TMP_CYC)) btam_chk_inst
  (.clk_i, .reset_i, .volt_i, .cur0_i, .temp_i, .external_trip_in_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
   .rd_data_o, .branch_on_o, .trip_alarm_out_o, .general_alarm_out_o, .overheat_out_o);

// ### tb/btam_monitor_tb_top.sv
// Bench for the monitor: register tasks on the plain port, plant model.
// Assumes shortened persistence counts; a run of some 300 cycles.
`timescale 1ns/100ps
module btam_monitor_tb_top;
  reg         clk_i;
  reg         reset_i;
  reg  [9:0]  volt_i;
  reg  [31:0] load;
  reg  [9:0]  runtime_i;
  reg  [7:0]  temp_i;
  reg         contact;
  reg  [7:0]  addr_i;
  reg  [31:0] wr_data_i;
  reg         wr_i;
  reg         rd_i;
  reg         sv;
  wire [7:0]  cur0_i;
  wire [7:0]  cur1_i;
  wire [7:0]  cur2_i;
  wire [7:0]  cur3_i;
  wire        external_trip_in_i;
  wire [31:0] rd_data_o;
  wire [3:0]  branch_on_o;
  wire        trip_alarm_out_o;
  wire        general_alarm_out_o;
  wire        overheat_out_o;
  wire [11:0] err_code_o;
  wire [9:0]  err_value_o;
  wire        err_show_value_o;
  wire        irq_o;
  integer     n_errors = 0;
  integer     checked = 0;

  // Redundant path is off, so its timer keeps its default length
  localparam [25:0] T_TRIP = 26'd10;
  btam_monitor #(.OVTRIP_CYC(T_TRIP), .SC_CYC(T_TRIP), .STD_CYC(26'd20),
    .FAST_CYC(26'd5), .TMP_CYC(26'd30), .ALT_CYC(26'd8)) btam_monitor_inst
    (.clk_i, .reset_i, .volt_i, .cur0_i, .cur1_i, .cur2_i, .cur3_i, .runtime_i, .temp_i,
     .external_trip_in_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .branch_on_o,
     .trip_alarm_out_o, .general_alarm_out_o, .overheat_out_o, .err_code_o, .err_value_o,
     .err_show_value_o, .irq_o);
  btam_plant btam_plant_inst (.branch_on_i(branch_on_o), .load_i(load), .contact_i(contact),
    .cur0_o(cur0_i), .cur1_o(cur1_i), .cur2_o(cur2_i), .cur3_o(cur3_i), .ext_trip_o(external_trip_in_i));

  always #12.5 clk_i = ~clk_i;
  // ==========================================================
  // Tasks
  task check(input string name, input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check("rd_data", rd_data_o, exp);
  end
  endtask
  // Code fff means the displayed code is not judged
  task outs(input [3:0] on, input [2:0] pins, input [11:0] code);
  begin
    #1 check("branch_on", {28'h0, branch_on_o}, {28'h0, on});
    check("pins", {29'h0, overheat_out_o, general_alarm_out_o, trip_alarm_out_o}, {29'h0, pins});
    if (code !== 12'hfff)
      check("err_code", {20'h0, err_code_o}, {20'h0, code});
    @(posedge clk_i);
  end
  endtask
  task report_and_stop;
  begin
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #300000;
    n_errors = n_errors + 1;
    report_and_stop;
  end
  // ==========================================================
  // Sequence
  initial
  begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    volt_i = 10'd240;
    load = {4{8'd10}};
    runtime_i = 10'd0;
    temp_i = 8'd30;
    contact = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sv = 1'b0;
    cyc(5);
    reset_i <= 1'b0;
    cyc(2);
    outs(4'hf, 3'h7, 12'h000);
    rd(8'h04, 32'h120);
    rd(8'h08, 32'h0b4);
    rd(8'h0c, 32'h000);
    rd(8'h10, 32'h050);
    rd(8'h18, 32'h02828);
    rd(8'h3c, 32'h0);
    cyc(1);
    volt_i <= 10'd289;
    cyc(9);
    volt_i <= 10'd240;
    cyc(14);
    outs(4'hf, 3'h7, 12'hfff);
    volt_i <= 10'd289;
    cyc(14);
    outs(4'h0, 3'h4, 12'ha10);
    volt_i <= 10'd240;
    rd(8'h30, 32'h09);
    wr(8'h34, 32'h01);
    cyc(2);
    #1 check("irq", {31'h0, irq_o}, 32'h1);
    wr(8'h30, 32'hff);
    cyc(2);
    #1 check("irq", {31'h0, irq_o}, 32'h0);
    wr(8'h34, 32'h0);
    cyc(5);
    outs(4'h0, 3'h6, 12'hfff);
    wr(8'h00, 32'h1);
    cyc(3);
    outs(4'hf, 3'h7, 12'hfff);
    // Exactly the short-circuit level on one branch
    load[7:0] <= 8'd90;
    cyc(14);
    outs(4'he, 3'h6, 12'ha11);
    load[7:0] <= 8'd10;
    wr(8'h00, 32'h1);
    wr(8'h20, 32'h12814);
    wr(8'h24, 32'h02814);
    load[31:16] <= {2{8'd25}};
    cyc(9);
    outs(4'hb, 3'h6, 12'ha11);
    cyc(16);
    outs(4'h3, 3'h6, 12'ha11);
    #1 sv = err_show_value_o;
    cyc(8);
    #1 check("show", {31'h0, err_show_value_o}, {31'h0, ~sv});
    @(posedge clk_i);
    load[31:16] <= {2{8'd10}};
    wr(8'h00, 32'h1);
    wr(8'h18, 32'h20a28);
    load[7:0] <= 8'd15;
    cyc(9);
    outs(4'hf, 3'h5, 12'ha22);
    load[7:0] <= 8'd10;
    cyc(3);
    outs(4'hf, 3'h7, 12'hfff);
    volt_i <= 10'd170;
    cyc(3);
    outs(4'hf, 3'h5, 12'ha21);
    wr(8'h04, 32'd250);
    volt_i <= 10'd260;
    cyc(3);
    #1 check("err_value", {22'h0, err_value_o}, 32'd260);
    outs(4'hf, 3'h5, 12'ha20);
    volt_i <= 10'd240;
    runtime_i <= 10'd50;
    cyc(3);
    outs(4'hf, 3'h7, 12'hfff);
    wr(8'h0c, 32'd50);
    cyc(3);
    outs(4'hf, 3'h5, 12'ha23);
    wr(8'h0c, 32'h0);
    temp_i <= 8'd81;
    cyc(29);
    temp_i <= 8'd70;
    cyc(34);
    outs(4'hf, 3'h7, 12'hfff);
    temp_i <= 8'd81;
    cyc(34);
    outs(4'hf, 3'h3, 12'ha30);
    temp_i <= 8'd80;
    wr(8'h1c, 32'h42828);
    contact <= 1'b1;
    cyc(4);
    contact <= 1'b0;
    cyc(3);
    #1 check("err_code", {20'h0, err_code_o}, 32'hf0e);
    outs(4'hd, 3'h7, 12'hfff);
    wr(8'h00, 32'h1);
    cyc(3);
    outs(4'hf, 3'h7, 12'hfff);
    report_and_stop;
  end
endmodule // btam_monitor_tb_top
